// ### logic/rx_lane_pkg.sv
// Shared constants for the receive packet lane.
package rx_lane_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  // A FIFO word: data byte, start, end and error marks.
  localparam int ENTRY_W = DATA_W + 3;
  localparam int SOP_BIT = DATA_W;
  localparam int EOP_BIT = DATA_W + 1;
  localparam int ERR_BIT = DATA_W + 2;
  // In-band port address sent with the start-of-transfer indicator.
  localparam logic [7:0] PORT_ADDR = 8'h00;
  // Link clock divider for the reading end: the link clock toggles when the
  // count equals this value, so zero gives 200 MHz / 2 = 100 MHz.
  localparam logic [1:0] LINK_DIV_HALF = 2'h0;
  localparam logic [1:0] DIV_ZERO = 2'h0;
endpackage

// ### logic/rx_lane_if.sv
// Link interface between the receive lane and its reader.
`timescale 1ns/1ps
`default_nettype none
interface rx_lane_if;
  logic link_clk;
  logic [7:0] rdata;
  logic rparity;
  logic renb_n;
  logic rval;
  logic rsop;
  logic reop;
  logic rerr;
  logic rsx;
  modport dev (input link_clk, input renb_n, output rdata, output rparity,
    output rval, output rsop, output reop, output rerr, output rsx);
  modport rdr (output link_clk, output renb_n, input rdata, input rparity,
    input rval, input rsop, input reop, input rerr, input rsx);
endinterface
`default_nettype wire

// ### logic/rx_fifo.sv
// Small flip-flop FIFO used in the receive data path.
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [AW:0] wr_d;
  logic [AW:0] rd_d;
  logic ready_q;
  logic valid_q;
  logic push;
  logic pop;
  logic full_d;

  // Flags are registered from the next pointers, so both handshake outputs
  // come straight from flip-flops; this costs one comparator per flag.
  assign push = in_valid && ready_q;
  assign pop = out_ready && valid_q;
  assign wr_d = wr_q + {{AW{1'b0}}, push};
  assign rd_d = rd_q + {{AW{1'b0}}, pop};
  // Extra pointer bit tells full from empty.
  assign full_d = (wr_d[AW] != rd_d[AW]) &&
                  (wr_d[AW-1:0] == rd_d[AW-1:0]);
  assign in_ready = ready_q;
  assign out_valid = valid_q;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // Pointers advance only on a completed handshake.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      ready_q <= !full_d;
      valid_q <= (wr_d != rd_d);
    end
  end

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ### logic/rx_lane_dev.sv
// Device end of the receive lane: FIFO-fed byte lane on the link clock.
//
// Function
// - Drive payload and port address on lane.
// - Reader supplies the link clock, 90-133 MHz.
// - Launch all outputs on rising link edge.
// - Odd parity by default, even selectable.
// - Parity meaningful only with valid or RSX.
// - Lane parity covers own eight data bits.
// - Enable low: read word, update outputs next.
// - Enable high: no read, outputs held.
// - Reader may pause at any cycle.
// - Reader qualifies everything by valid.
// - Per-lane enable gates its own signals.
// - Valid low between transfers, RSX, empty.
// - RSX only in cycles with valid low.
// - Start mark on first word with valid.
// - Error only together with end mark.
`timescale 1ns/1ps
`default_nettype none
module rx_lane_dev
  import rx_lane_pkg::*;
(
  rx_lane_if.dev link,
  input wire logic rstn,
  input wire logic even_parity,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic in_err
);
  // ********************************************************************
  // Link timing
  // ********************************************************************
  // Everything here runs on the link clock that the reader supplies, so
  // the push side, the FIFO and the lane outputs share one domain and no
  // word crosses clocks inside this end. The price is that the pusher must
  // also be timed by the link clock.
  //
  // One packet on the lane, edge by edge, with the enable held low:
  //   edge 1: start-of-transfer mark high, lane carries the port address,
  //           valid low;
  //   edge 2: mark low, valid low, the address cycle is over;
  //   edge 3: first byte with the start mark and valid high;
  //   edge n: last byte with the end mark and, if bad, the error flag;
  //   then:   valid low again on the next read, which may already open the next address cycle.
  // A high enable freezes every output, so the walk simply stretches.
  //
  // The external reset and the parity select arrive from another domain
  // and pass two flip-flops each before anything reads them. The link
  // clock must run while reset is low, or the lane state is never reset.

  // ********************************************************************
  // State
  // ********************************************************************
  // Lane phase: idle, address cycle, payload.
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ADDR = 2'b01,
    S_DATA = 2'b11
  } phase_e;

  // All state in one word; both synchroniser pairs live here too.
  typedef struct packed {
    phase_e phase;
    logic [1:0] rst_sync;
    logic [1:0] par_sync;
    logic [DATA_W-1:0] rdata;
    logic rparity;
    logic rval;
    logic rsop;
    logic reop;
    logic rerr;
    logic rsx;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic f_valid;
  logic f_ready;
  logic [ENTRY_W-1:0] f_data;
  logic run;
  logic odd_sel;
  logic head_drop;

  // The whole device end lives on the link clock, as the reader owns it.
  // Sixteen words absorb the reader's pauses without losing a byte.
  rx_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) fifo_u (
    .clock(link.link_clk),
    .rstn(run),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({in_err, in_eop, in_sop, in_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Reset and the parity strap come from outside, so both are synchronised.
  assign run = st_q.rst_sync[1];
  assign odd_sel = !st_q.par_sync[1];

  // Parity is fixed when a word is loaded, so a held word keeps it even if
  // the select changes; change the select only between packets.
  function automatic logic lane_parity(input logic [DATA_W-1:0] d,
                                       input logic odd);
    lane_parity = (^d) ^ odd;
  endfunction

  // A word is taken while the lane streams a packet, or dropped at the
  // head when it opens none, so a stray word cannot block the lane.
  assign head_drop = (st_q.phase == S_IDLE) && f_valid && !f_data[SOP_BIT];
  assign f_ready = run && !link.renb_n &&
                   ((st_q.phase == S_DATA) || head_drop);

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    st_d = st_q;
    st_d.rst_sync = {st_q.rst_sync[0], rstn};
    st_d.par_sync = {st_q.par_sync[0], even_parity};
    // Enable high leaves every output unchanged.
    if (!link.renb_n) begin
      unique case (st_q.phase)
        S_IDLE: begin
          // Announce the port with RSX while valid is low.
          st_d.rval = 1'b0;
          st_d.rsop = 1'b0;
          st_d.reop = 1'b0;
          st_d.rerr = 1'b0;
          st_d.rsx = 1'b0;
          if (f_valid && f_data[SOP_BIT]) begin
            st_d.rsx = 1'b1;
            st_d.rdata = PORT_ADDR;
            st_d.rparity = lane_parity(PORT_ADDR, odd_sel);
            st_d.phase = S_ADDR;
          end else if (f_valid) begin
            // A head word that opens no packet is popped and lost.
            st_d.phase = S_IDLE;
          end
        end
        S_ADDR: begin
          // The address cycle closes; payload follows on the next read.
          st_d.rsx = 1'b0;
          st_d.rval = 1'b0;
          st_d.phase = S_DATA;
        end
        S_DATA: begin
          st_d.rsx = 1'b0;
          if (f_valid) begin
            st_d.rval = 1'b1;
            st_d.rdata = f_data[DATA_W-1:0];
            st_d.rparity = lane_parity(f_data[DATA_W-1:0], odd_sel);
            st_d.rsop = f_data[SOP_BIT];
            st_d.reop = f_data[EOP_BIT];
            st_d.rerr = f_data[ERR_BIT] && f_data[EOP_BIT];
            // The end mark returns the lane to idle; valid drops next read.
            if (f_data[EOP_BIT]) begin
              st_d.phase = S_IDLE;
            end
          end else begin
            // Paused on an empty FIFO: valid drops.
            st_d.rval = 1'b0;
            st_d.rsop = 1'b0;
            st_d.reop = 1'b0;
            st_d.rerr = 1'b0;
          end
        end
        default: st_d.phase = S_IDLE;
      endcase
    end
    if (!run) begin
      st_d.phase = S_IDLE;
      st_d.rdata = '0;
      st_d.rparity = 1'b0;
      st_d.rval = 1'b0;
      st_d.rsx = 1'b0;
      st_d.rsop = 1'b0;
      st_d.reop = 1'b0;
      st_d.rerr = 1'b0;
    end
  end

  // ********************************************************************
  // Registers, launched on the rising link edge
  // ********************************************************************
  // No reset here: the synchronised reset acts in the next-state logic,
  // which keeps the single registered copy of the state simple.
  always_ff @(posedge link.link_clk) begin
    st_q <= st_d;
  end

  // Outputs come straight from the registered state.
  // Data and parity read zero after reset until the first load.
  assign link.rdata = st_q.rdata;
  assign link.rparity = st_q.rparity;
  assign link.rval = st_q.rval;
  assign link.rsop = st_q.rsop;
  assign link.reop = st_q.reop;
  assign link.rerr = st_q.rerr;
  assign link.rsx = st_q.rsx;
endmodule
`default_nettype wire

// ### logic/rx_lane_rdr.sv
// Reader end: makes the link clock and accepts words from the lane.
`timescale 1ns/1ps
`default_nettype none
module rx_lane_rdr
  import rx_lane_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  rx_lane_if.rdr link,
  input wire logic accept,
  output logic out_valid,
  output logic [DATA_W-1:0] out_data,
  output logic out_sop,
  output logic out_eop,
  output logic out_err,
  output logic out_par_err
);
  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [1:0] div;
    logic lclk;
    logic renb_n;
    logic valid;
    logic [DATA_W-1:0] data;
    logic sop;
    logic eop;
    logic err;
    logic par_err;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic fall;

  // The reader is the link clock source. It samples the lane and moves its
  // enable at the falling link edge, half a link cycle away from the edge
  // that launches the lane and samples the enable, so neither side races.
  assign fall = (st_q.div == LINK_DIV_HALF) && st_q.lclk;

  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    if (st_q.div == LINK_DIV_HALF) begin
      st_d.div = DIV_ZERO;
      st_d.lclk = !st_q.lclk;
    end else begin
      st_d.div = st_q.div + 2'h1;
    end
    if (fall) begin
      // The lane shows what the enable set at the last fall requested; a
      // word held under a high enable is not counted twice.
      st_d.renb_n = !accept;
      if (link.rval && !st_q.renb_n) begin
        st_d.valid = 1'b1;
        st_d.data = link.rdata;
        st_d.sop = link.rsop;
        st_d.eop = link.reop;
        st_d.err = link.rerr && link.reop;
        // Odd check only: in even mode every word is flagged.
        st_d.par_err = !(^{link.rdata, link.rparity});
      end
    end
    if (!rstn) begin
      st_d = '0;
      st_d.renb_n = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  assign link.link_clk = st_q.lclk;
  assign link.renb_n = st_q.renb_n;
  assign out_valid = st_q.valid;
  assign out_data = st_q.data;
  assign out_sop = st_q.sop;
  assign out_eop = st_q.eop;
  assign out_err = st_q.err;
  assign out_par_err = st_q.par_err;
endmodule
`default_nettype wire

// ### sim/rx_lane_properties.sv
// Checker of the receive lane link signals.
`timescale 1ns/1ps
`default_nettype none
module rx_lane_properties (
  input wire logic link_clk,
  input wire logic rstn,
  input wire logic even_parity,
  input wire logic [7:0] rdata,
  input wire logic rparity,
  input wire logic renb_n,
  input wire logic rval,
  input wire logic rsop,
  input wire logic reop,
  input wire logic rerr,
  input wire logic rsx
);
  // ********
  // Link checks
  // ********
  // One domain only, so clock and reset are stated once.
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rstn);
  AST_HOLD: assert property (renb_n |=>
    $stable({rdata, rparity, rval, rsop, reop, rerr, rsx}))
    else $error("lane moved without a read");
  AST_PARITY: assert property ((rval || rsx) |->
    (^{rdata, rparity}) != even_parity) else $error("bad lane parity");
  AST_ERR_EOP: assert property (rerr |-> reop && rval)
    else $error("error flag without end mark");
  AST_SOP_VAL: assert property (rsop |-> rval)
    else $error("start mark without valid");
  AST_RSX_IDLE: assert property (rsx |-> !rval)
    else $error("start of transfer with valid high");
  AST_RSX_ONE: assert property (rsx && !renb_n |=> !rsx)
    else $error("start of transfer not advanced");
  AST_EOP_GAP: assert property (reop && rval && !renb_n |=> !rval)
    else $error("valid stayed high after end mark");
  AST_EOP_VAL: assert property (reop |-> rval)
    else $error("end mark without valid");
  // Main scenarios that the bench must reach.
  cover property (rsx);
  cover property (rerr);
  cover property (rval && renb_n);
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench joining both ends of the receive lane.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rx_lane_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic dev_rstn = 1'b0;
  logic even_parity = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [DATA_W-1:0] in_data = 8'h00;
  logic in_sop = 1'b0;
  logic in_eop = 1'b0;
  logic in_err = 1'b0;
  logic accept = 1'b0;
  logic out_valid, out_sop, out_eop, out_err, out_par_err;
  logic [DATA_W-1:0] out_data;
  logic [ENTRY_W-1:0] exp_q[$];
  int acc_mode = 0;
  int err_total = 0;
  int n_compared = 0;
  rx_lane_if link_if();
  rx_lane_dev rx_lane_dev_inst (.link(link_if.dev), .rstn(dev_rstn),
    .even_parity(even_parity), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .in_err(in_err));
  rx_lane_rdr rx_lane_rdr_inst (.clock(clock), .rstn(rstn),
    .link(link_if.rdr), .accept(accept), .out_valid(out_valid),
    .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop),
    .out_err(out_err), .out_par_err(out_par_err));
  rx_lane_properties rx_lane_properties_inst (.link_clk(link_if.link_clk),
    .rstn(dev_rstn), .even_parity(even_parity), .rdata(link_if.rdata),
    .rparity(link_if.rparity), .renb_n(link_if.renb_n),
    .rval(link_if.rval), .rsop(link_if.rsop), .reop(link_if.reop),
    .rerr(link_if.rerr), .rsx(link_if.rsx));
  // ********
  // Helpers
  // ********
  always #2.5 clock = ~clock;
  task automatic check(input string what, input logic [10:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Pushes one packet; the FIFO may refuse, so each word waits on ready.
  task automatic send(input int len);
    logic [10:0] w;
    int n;
    logic rdy;
    for (int i = 0; i < len; i++) begin
      w = {1'($urandom) & (i == len - 1), i == len - 1, i == 0, 8'($urandom)};
      in_valid <= 1'b1;
      {in_err, in_eop, in_sop, in_data} <= w;
      for (n = 0; n < 3000; n++) begin
        @(negedge link_if.link_clk);
        rdy = in_ready;
        @(posedge link_if.link_clk);
        if (rdy === 1'b1) break;
      end
      if (n == 3000) begin
        err_total++;
        stop_test();
      end
      exp_q.push_back(w);
    end
    in_valid <= 1'b0;
    @(posedge link_if.link_clk);
  endtask
  task automatic drain(input string name);
    for (int n = 0; n < 20000 && exp_q.size() != 0; n++) @(posedge clock);
    check("queue empty", 11'(exp_q.size()), 11'h000);
    $display("test %s done", name);
  endtask
  // Reader willingness: stalled, random pauses, or always on.
  always @(posedge clock) begin
    accept <= (acc_mode == 1) ? ($urandom_range(0, 3) != 0) : (acc_mode == 2);
  end
  // Each word seen at the reader must be the oldest one pushed.
  always @(posedge clock) begin
    if (rstn && out_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("extra word", 11'h7ff, 11'h000);
      end else begin
        check("word", {out_err, out_eop, out_sop, out_data},
          exp_q.pop_front());
        check("parity flag", 11'(out_par_err), 11'(even_parity));
      end
    end
  end
  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(70532));
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (8) @(posedge link_if.link_clk);
    dev_rstn <= 1'b1;
    repeat (4) @(posedge link_if.link_clk);
    for (int p = 0; p < 2; p++) begin
      // The parity select moves only while the lane shows nothing valid.
      for (int n = 0; n < 100 && link_if.rval !== 1'b0; n++) begin
        @(posedge link_if.link_clk);
      end
      check("valid idle", 11'(link_if.rval), 11'h000);
      even_parity <= p[0];
      acc_mode = 1 + p;
      repeat (10) @(posedge link_if.link_clk);
      for (int k = 0; k < 6; k++) send($urandom_range(1, 5));
      drain(p == 0 ? "odd parity pauses" : "even parity");
    end
    // Stalled reader: the FIFO must fill up and refuse further words.
    acc_mode = 0;
    fork
      send(2 * FIFO_DEPTH);
      begin
        for (int n = 0; n < 3000 && in_ready !== 1'b0; n++) @(posedge clock);
        check("fifo refuses", 11'(in_ready), 11'h000);
        acc_mode = 1;
      end
    join
    drain("fill and drain");
    stop_test();
  end
endmodule
`default_nettype wire
